// >>> segment_lcd_frame_control.v
/*
  frame level control and status for a segment display driver:
  enable, waveform choice, per-frame latching, blanking, frame flag.
  assumes an avalon-mm master on the same clock, and a frame tick
  counter built here from the system clock.
*/
// Local design decision: the Avalon-MM interface to the registers.
// Overview of operation
// [RL1] latch memory, blanking, waveform, contrast at frame
// [RL2] software writes accepted at any time
// [RL3] enable bit starts; clearing stops at once
// [RL4] disabled: pins return to port function
// [RL5] bit 6 picks low power waveform
// [RL6] waveform change applies at next frame
// [RL7] bit 5 reserved, reads zero
// [RL8] frame flag set with the data latch
// [RL9] irq needs flag, enable, global enable
// [RL10] flag cleared on interrupt vector taken
// [RL11] writing one to flag clears it
// [RL12] low power: flag and latch every second frame
// [RL13] bit 2 bypasses bias buffers
// [RL14] software configures before enabling
// [RL15] software disables before reconfiguring
// [RL16] blanking drives all pins to ground
// [RL17] software disable sequence uses flag twice
// [RL18] software sets port pins safe first
// [RL19] blanking applies after current frame ends
// [RL20] zero to flag no effect; read-only ignored
// [RL21] control register resets to zero
`default_nettype none
`include "lcd_frame_map.vh"

module segment_lcd_frame_control #(
  parameter MEM_DEPTH = 8,
  parameter MEM_AW = 3,
  parameter FRAME_LEN = `FRAME_LEN_DEFAULT
) (
  input wire clock,
  input wire sys_rst,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire global_irq_enable,
  input wire irq_vector_taken,
  output wire frame_irq,
  output wire pins_to_port,
  output reg pins_grounded,
  output reg bias_buffer_bypass,
  output reg active_low_power_wave,
  output reg [7:0] active_contrast,
  output reg [8*MEM_DEPTH-1:0] active_segments,
  output reg frame_start_pulse
);

  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_DONE = 2'd2;

  reg display_enable;
  reg low_power_wave_select;
  reg frame_start_flag;
  reg frame_irq_enable;
  reg blanking_request;
  reg [7:0] contrast_control_word;
  reg [15:0] frame_len_cfg;
  reg [15:0] frame_count;
  reg frame_parity;
  reg [1:0] bus_state;
  reg [1:0] next_bus_state;

  // next values, kept apart from the registers they feed
  reg [15:0] next_frame_count;
  reg next_frame_start_flag;
  reg [31:0] next_readdata;
  reg [7:0] rd_addr_q;
  wire [7:0] seg_rd;
  wire [8*MEM_DEPTH-1:0] seg_all;

  function is_mem;
    input [7:0] a;
    begin
      is_mem = (a[7:2] < MEM_DEPTH);
    end
  endfunction

  function [7:0] ctrl_image;
    input en, lp, fl, ie, bd, ccd, bl;
    begin
      ctrl_image = {en, lp, 1'b0, fl, ie, bd, ccd, bl}; // RL7
    end
  endfunction

  // one lane-0 write match, shared by the control and contrast registers
  // lanes 1 to 3 carry nothing for these registers
  function lane0_hit;
    input take;
    input be0;
    input [7:0] a;
    input [7:0] target;
    begin
      lane0_hit = take && be0 && a == target;
    end
  endfunction

  // writes never wait; a write seen outside idle is dropped
  wire wr_take = avs_write && bus_state == ST_IDLE;
  wire wr_ctrl = lane0_hit(wr_take, avs_byteenable[0], avs_address,
                           `CTRL_STATUS_A_OFFSET);
  wire wr_contrast = lane0_hit(wr_take, avs_byteenable[0], avs_address,
                               `CONTRAST_OFFSET);
  wire wr_cfg = wr_take && avs_address == `FRAME_CFG_OFFSET;
  wire wr_mem = wr_take && is_mem(avs_address) && avs_byteenable[0];

  seg_memory #(
    .WIDTH(8),
    .DEPTH(MEM_DEPTH),
    .AW(MEM_AW)
  ) u_mem (
    .clock(clock),
    .wr_en(wr_mem), // RL2
    .wr_addr(avs_address[MEM_AW+1:2]),
    .wr_data(avs_writedata[7:0]),
    .rd_addr(avs_address[MEM_AW+1:2]),
    .rd_data(seg_rd),
    .all_data(seg_all)
  );

  // frame tick from system clock; a real part uses the prescaled clock
  wire frame_end = display_enable && frame_count == 16'h0000;
  // low power needs two equal frames, so latch on alternate ends only
  wire latch_now = frame_end &&
                   (!active_low_power_wave || frame_parity); // RL12

  // reload from the software length, so a new length applies
  // from the following frame on
  always @* begin
    next_frame_count = frame_count - 16'h0001;
    if (frame_count == 16'h0000) begin
      next_frame_count = frame_len_cfg;
    end
  end

  // parity starts at one so the first frame after enable always latches
  always @(posedge clock) begin
    if (sys_rst || !display_enable) begin
      frame_count <= 16'h0000;
      frame_parity <= 1'b1;
    end else begin
      frame_count <= next_frame_count;
      if (frame_count == 16'h0000) begin
        frame_parity <= ~frame_parity;
      end
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      display_enable <= 1'b0; // RL21
      low_power_wave_select <= 1'b0;
      frame_irq_enable <= 1'b0;
      blanking_request <= 1'b0;
      bias_buffer_bypass <= 1'b0;
    end else if (wr_ctrl) begin
      display_enable <= avs_writedata[`BIT_DISPLAY_ENABLE]; // RL3
      low_power_wave_select <= avs_writedata[`BIT_LOW_POWER_WAVE]; // RL5
      frame_irq_enable <= avs_writedata[`BIT_FRAME_IRQ_EN];
      blanking_request <= avs_writedata[`BIT_BLANKING];
      bias_buffer_bypass <= avs_writedata[`BIT_BIAS_BYPASS]; // RL13
    end
  end

  // set wins over a clear in the same cycle
  always @* begin
    next_frame_start_flag = frame_start_flag;
    if (wr_ctrl && avs_writedata[`BIT_FRAME_FLAG]) begin
      next_frame_start_flag = 1'b0; // RL11 RL20
    end
    if (irq_vector_taken && frame_irq) begin
      next_frame_start_flag = 1'b0; // RL10
    end
    if (latch_now) begin
      next_frame_start_flag = 1'b1; // RL8
    end
  end

  always @(posedge clock) begin
    if (sys_rst || !display_enable) begin
      frame_start_flag <= 1'b0;
    end else begin
      frame_start_flag <= next_frame_start_flag;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      contrast_control_word <= 8'h00;
      frame_len_cfg <= FRAME_LEN[15:0];
    end else begin
      if (wr_contrast) begin
        contrast_control_word <= avs_writedata[7:0]; // RL2
      end
      if (wr_cfg && avs_byteenable[0]) begin
        frame_len_cfg[7:0] <= avs_writedata[7:0];
      end
      if (wr_cfg && avs_byteenable[1]) begin
        frame_len_cfg[15:8] <= avs_writedata[15:8];
      end
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      active_segments <= {8*MEM_DEPTH{1'b0}};
      active_contrast <= 8'h00;
      active_low_power_wave <= 1'b0;
      pins_grounded <= 1'b0;
      frame_start_pulse <= 1'b0;
    end else begin
      frame_start_pulse <= latch_now;
      // blanking only takes hold at a frame boundary
      if (latch_now) begin
        active_segments <= seg_all; // RL1
        active_contrast <= contrast_control_word;
        active_low_power_wave <= low_power_wave_select; // RL6
        pins_grounded <= blanking_request; // RL16 RL19
      end
      if (!display_enable) begin
        pins_grounded <= 1'b0;
      end
    end
  end

  assign pins_to_port = !display_enable; // RL3 RL4
  assign frame_irq = frame_start_flag && frame_irq_enable
                     && global_irq_enable; // RL9

  // reads take three cycles, waitrequest high for the first two, so memory read data are registered
  always @* begin
    next_bus_state = bus_state;
    case (bus_state)
      ST_IDLE: begin
        if (avs_read) begin
          next_bus_state = ST_WAIT;
        end
      end
      ST_WAIT: next_bus_state = ST_DONE;
      ST_DONE: next_bus_state = ST_IDLE;
      default: next_bus_state = ST_IDLE;
    endcase
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      bus_state <= ST_IDLE;
      rd_addr_q <= 8'h00;
    end else begin
      bus_state <= next_bus_state;
      if (bus_state == ST_IDLE) begin
        rd_addr_q <= avs_address;
      end
    end
  end

  assign avs_waitrequest = avs_read && bus_state != ST_DONE;

  // read word chosen while the request waits; bit 1 stays zero
  // unmapped addresses read as zero
  always @* begin
    next_readdata = 32'h00000000;
    if (rd_addr_q == `CTRL_STATUS_A_OFFSET) begin
      next_readdata[7:0] = ctrl_image(display_enable,
        low_power_wave_select, frame_start_flag, frame_irq_enable,
        bias_buffer_bypass, 1'b0, blanking_request); // RL7
    end else if (rd_addr_q == `CONTRAST_OFFSET) begin
      next_readdata[7:0] = contrast_control_word;
    end else if (rd_addr_q == `FRAME_CFG_OFFSET) begin
      next_readdata[15:0] = frame_len_cfg;
    end else if (is_mem(rd_addr_q)) begin
      next_readdata[7:0] = seg_rd;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      avs_readdata <= 32'h00000000;
    end else if (bus_state == ST_WAIT) begin
      avs_readdata <= next_readdata;
    end
  end

endmodule

`default_nettype wire

// >>> lcd_frame_map.vh
/*
  register offsets, field positions, reset values and timing counts
  for the segment display frame control block.
  assumes inclusion by bare name from the design files.
*/
`ifndef LCD_FRAME_MAP_VH
`define LCD_FRAME_MAP_VH

`define CTRL_STATUS_A_OFFSET 8'he4
`define SEG_MEM_BASE_OFFSET 8'h00
`define CONTRAST_OFFSET 8'hd0
`define FRAME_CFG_OFFSET 8'hd4
`define CTRL_STATUS_A_RESET 8'h00
`define BIT_DISPLAY_ENABLE 7
`define BIT_LOW_POWER_WAVE 6
`define BIT_RESERVED_5 5
`define BIT_FRAME_FLAG 4
`define BIT_FRAME_IRQ_EN 3
`define BIT_BIAS_BYPASS 2
`define BIT_CONTRAST_SUPPLY_DIS 1
`define BIT_BLANKING 0
`define FRAME_LEN_DEFAULT 16'h0100

`endif

// >>> seg_memory.v
/*
  small display memory, one write port, registered read port.
  assumes a single clock shared with the register bus.
*/
`default_nettype none

module seg_memory #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data,
  output wire [WIDTH*DEPTH-1:0] all_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : flat
      assign all_data[g*WIDTH +: WIDTH] = mem[g];
    end
  endgenerate

endmodule

`default_nettype wire

// >>> lcd_glass_model.sv
/* passive segment glass at the far side.
   assumes the block's pin outputs, one clock. */
`default_nettype none
module lcd_glass_model (
  input wire logic clock,
  input wire logic pins_to_port,
  input wire logic pins_grounded,
  input wire logic [63:0] active_segments,
  output logic discharged
);
  timeunit 1ns;
  timeprecision 100ps;
  // charge builds while lit segments are driven
  always @(posedge clock) begin
    if (pins_grounded)
      discharged <= 1'b1;
    else if (!pins_to_port && |active_segments)
      discharged <= 1'b0;
  end
endmodule
`default_nettype wire

// >>> lcd_frame_asserts.sv
/* port checks for the frame control block.
   assumes bind from the bench, one clock. */
`default_nettype none
module lcd_frame_checks (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic global_irq_enable,
  input wire logic irq_vector_taken,
  input wire logic frame_irq,
  input wire logic pins_to_port,
  input wire logic pins_grounded,
  input wire logic bias_buffer_bypass,
  input wire logic active_low_power_wave,
  input wire logic [7:0] active_contrast,
  input wire logic frame_start_pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic ctl_wr = avs_write && avs_address == 8'he4;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_rsvd;
    avs_read && !avs_waitrequest && avs_address == 8'he4
      |-> avs_readdata[5] == 1'b0 && avs_readdata[1] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_on;
    ctl_wr && avs_writedata[7] |=> !pins_to_port;
  endproperty
  a_on: assert property (p_on) else $error("enable ignored");
  property p_off;
    ctl_wr && !avs_writedata[7] |=> pins_to_port;
  endproperty
  a_off: assert property (p_off) else $error("pins kept");
  property p_bd;
    ctl_wr |=> bias_buffer_bypass == $past(avs_writedata[2]);
  endproperty
  a_bd: assert property (p_bd) else $error("bypass wrong");
  property p_irq;
    frame_irq |-> global_irq_enable;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not gated");
  property p_vec;
    frame_irq && irq_vector_taken |=> !frame_irq || frame_start_pulse;
  endproperty
  a_vec: assert property (p_vec) else $error("flag kept");
  property p_wave;
    $changed(active_low_power_wave) && !pins_to_port
      |-> ##[0:1] frame_start_pulse;
  endproperty
  a_wave: assert property (p_wave) else $error("wave mid frame");
  property p_lat;
    $changed(active_contrast) && !pins_to_port |-> ##[0:1] frame_start_pulse;
  endproperty
  a_lat: assert property (p_lat) else $error("latch mid frame");
  property p_blank;
    $rose(pins_grounded) |-> ##[0:1] frame_start_pulse;
  endproperty
  a_blank: assert property (p_blank) else $error("blank mid frame");
  cover property (frame_irq && irq_vector_taken);
  cover property ($rose(pins_grounded));
  cover property (active_low_power_wave && frame_start_pulse);
endmodule
`default_nettype wire

// >>> segment_lcd_frame_control_test.sv
/* bench: registers, frames, irq, blanking, disable.
   assumes block, glass and checker compiled first. */
`default_nettype none
module segment_lcd_frame_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, sys_rst, avs_read, avs_write, avs_waitrequest, frame_irq;
  logic global_irq_enable, irq_vector_taken, pins_to_port, pins_grounded;
  logic bias_buffer_bypass, active_low_power_wave, frame_start_pulse;
  logic discharged;
  logic [7:0] avs_address, active_contrast, d, c;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [63:0] active_segments;
  integer err_total, cmp_count, seed, i, idx;
  // short frames keep the run brief
  segment_lcd_frame_control #(.FRAME_LEN(16'h0020))
    u_segment_lcd_frame_control (.clock, .sys_rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
    .avs_readdata, .avs_waitrequest, .global_irq_enable,
    .irq_vector_taken, .frame_irq, .pins_to_port, .pins_grounded,
    .bias_buffer_bypass, .active_low_power_wave, .active_contrast,
    .active_segments, .frame_start_pulse);
  lcd_glass_model u_lcd_glass_model (.clock, .pins_to_port,
    .pins_grounded, .active_segments, .discharged);
  always #12.5 clock = ~clock;
  task close_out;
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic [7:0] a, input logic [31:0] wd, input logic w);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0)
      @(posedge clock);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task pulse_wait;
    integer k;
    k = 0;
    @(negedge clock);
    while (frame_start_pulse !== 1'b1 && k < 200) begin
      @(negedge clock);
      k = k + 1;
    end
    chk(32'(k < 200), 32'h1);
  endtask
  // software style wait: poll the register until the flag reads one
  task flag_wait;
    q = 32'h0;
    while (q[4] !== 1'b1)
      bus(8'he4, 32'h0, 1'b0);
  endtask
  // phase of the window may shift the count by one
  task frames(input integer lo);
    integer k;
    pulse_wait;
    pulse_wait;
    k = 0;
    repeat (330) begin
      @(negedge clock);
      k = k + frame_start_pulse;
    end
    chk(32'(k >= lo && k <= lo + 2), 32'h1);
  endtask
  initial begin
    repeat (6000) @(posedge clock);
    err_total = err_total + 1;
    close_out;
  end
  initial begin
    {clock, avs_read, avs_write, irq_vector_taken} = 4'h0;
    {sys_rst, global_irq_enable} = 2'h3;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    {err_total, cmp_count} = 64'h0;
    seed = 32'h64eb2c19;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    bus(8'he4, 32'h0, 1'b0);
    chk(q, 32'h0);
    bus(8'hf0, 32'h5a, 1'b1);
    bus(8'hf0, 32'h0, 1'b0);
    chk(q, 32'h0);
    bus(8'hd4, 32'h20, 1'b1);
    bus(8'hd4, 32'h0, 1'b0);
    chk(q, 32'h20);
    bus(8'he4, 32'hff, 1'b1);
    bus(8'he4, 32'h0, 1'b0);
    chk(q & 32'hef, 32'hcd);
    chk(32'({bias_buffer_bypass, pins_to_port}), 32'h2);
    bus(8'he4, 32'h88, 1'b1);
    pulse_wait;
    bus(8'he4, 32'h0, 1'b0);
    chk(q & 32'h10, 32'h10);
    bus(8'he4, 32'h88, 1'b1);
    @(negedge clock);
    chk(32'(frame_irq), 32'h1);
    @(posedge clock);
    global_irq_enable <= 1'b0;
    @(negedge clock);
    chk(32'(frame_irq), 32'h0);
    @(posedge clock);
    global_irq_enable <= 1'b1;
    irq_vector_taken <= 1'b1;
    @(posedge clock);
    irq_vector_taken <= 1'b0;
    @(negedge clock);
    chk(32'(frame_irq), 32'h0);
    pulse_wait;
    bus(8'he4, 32'h98, 1'b1);
    @(negedge clock);
    chk(32'(frame_irq), 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      idx = $random(seed) & 7;
      d = 8'($random(seed));
      c = 8'($random(seed));
      bus(8'(idx * 4), 32'(d), 1'b1);
      bus(8'hd0, 32'(c), 1'b1);
      bus(8'(idx * 4), 32'h0, 1'b0);
      chk(q, 32'(d));
      pulse_wait;
      pulse_wait;
      chk(32'(active_segments[8*idx +: 8]), 32'(d));
      chk(32'(active_contrast), 32'(c));
    end
    bus(8'he4, 32'hc0, 1'b1);
    frames(4);
    chk(32'(active_low_power_wave), 32'h1);
    bus(8'he4, 32'h80, 1'b1);
    frames(9);
    bus(8'he4, 32'h90, 1'b1);
    flag_wait;
    bus(8'he4, 32'h91, 1'b1);
    @(negedge clock);
    chk(32'(pins_grounded), 32'h0);
    flag_wait;
    chk(32'({pins_grounded, discharged}), 32'h3);
    bus(8'he4, 32'h0, 1'b1);
    @(negedge clock);
    chk(32'(pins_to_port), 32'h1);
    close_out;
  end
endmodule
bind segment_lcd_frame_control lcd_frame_checks u_lcd_frame_checks (
  .clock, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .global_irq_enable, .irq_vector_taken,
  .frame_irq, .pins_to_port, .pins_grounded, .bias_buffer_bypass,
  .active_low_power_wave, .active_contrast, .frame_start_pulse);
`default_nettype wire
